// ==== tsr_core.sv ====
// Serial thermal sensor: frame engine, mode control, result and id words
//
// Functional notes
// - Mode control word is write only, never read.
// - Low byte all ones selects shutdown.
// - Any zero in low byte means continuous.
// - Continuous conversion after reset, no write needed.
// - Serial interface keeps working in shutdown.
// - Reading register is read only.
// - Bits one and zero of reading undriven.
// - Bit two set after first conversion, sticky.
// - Bit two zero until first conversion.
// - Value in bits 15:3, two's complement.
// - Id word read only in shutdown.
// - Maker code in id upper byte.
// - Id bits 7:2 zero, 1:0 undriven.
// - First bit at select, then shift on fall.
// - Release line after fourteen bits.
// - Sixteen pulses out, then sixteen in.
// - One value step is 1/16 degree.
`timescale 1ns/1ps
`default_nettype none
module tsr_core import tsr_pkg::*; #(
  parameter int CONV_CYCLES_P = CONV_CYCLES
) (
  input wire logic clk_sys, // System clock, 40 MHz
  input wire logic srst, // Synchronous reset, high
  input wire logic cs_n, // Chip select pin, low active
  input wire logic sck, // Serial clock pin
  input wire logic sio_in, // Data line level
  output logic sio_out, // Data line drive value
  output logic sio_oe_n, // Low while driving
  input wire logic [TEMP_W-1:0] temp_code, // Front end value
  output logic shutdown_active, // Shutdown mode
  output logic first_conv_done // First conversion done
);
  tsr_state_t state;
  logic [2:0] pins_sync;
  logic cs_n_s;
  logic sck_s;
  logic sio_s;
  logic sck_q;
  logic cs_n_q;
  logic cs_act;
  logic cs_fall;
  logic sck_rise;
  logic sck_fall;
  logic [CNT_W-1:0] pulse_cnt;
  logic [CNT_W-1:0] tx_idx;
  logic [CNT_W-1:0] rx_cnt;
  logic [WORD_BITS-1:0] tx_shift;
  logic [WORD_BITS-1:0] rx_shift;
  logic [WORD_BITS-1:0] next_rx;
  logic [WORD_BITS-1:0] read_word;
  logic [WORD_BITS-1:0] mode_control_bits;
  logic [TEMP_W-1:0] reading;
  logic [CONV_CNT_W-1:0] conv_cnt;
  logic conv_end;
  logic conv_push;
  logic buf_in_ready;
  logic buf_out_valid;
  logic [TEMP_W-1:0] buf_out_data;
  logic load_reading;
  logic word_full;
  logic word_partial;

  // Pin synchronisers
  tsr_sync u_sync (
    .clk_sys(clk_sys),
    .srst(srst),
    .pin_in({cs_n, sck, sio_in}),
    .pin_sync(pins_sync)
  );
  assign cs_n_s = pins_sync[2];
  assign sck_s = pins_sync[1];
  assign sio_s = pins_sync[0];

  // Edge history of synchronised pins
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sck_q <= 1'b0;
      cs_n_q <= 1'b1;
    end else begin
      sck_q <= sck_s;
      cs_n_q <= cs_n_s;
    end
  end

  // Clock edges count only while selected
  assign cs_act = ~cs_n_s;
  assign cs_fall = cs_n_q && !cs_n_s;
  assign sck_rise = cs_act && sck_s && !sck_q;
  assign sck_fall = cs_act && !sck_s && sck_q;

  // Frame sequencing: read half then write half
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state <= TSR_IDLE;
    end else begin
      unique case (state)
        TSR_IDLE: begin
          if (cs_fall) begin
            state <= TSR_READ;
          end
        end
        TSR_READ: begin
          if (!cs_act) begin
            state <= TSR_IDLE;
          end else if (sck_rise && pulse_cnt == CNT_W'(WORD_BITS - 1)) begin
            state <= TSR_WRITE;
          end
        end
        TSR_WRITE: begin
          if (!cs_act) begin
            state <= TSR_IDLE;
          end else if (word_full) begin
            state <= TSR_DONE;
          end
        end
        TSR_DONE: begin
          if (!cs_act) begin
            state <= TSR_IDLE;
          end
        end
      endcase
    end
  end

  // Read half pulse counter
  always_ff @(posedge clk_sys) begin
    if (srst || state == TSR_IDLE) begin
      pulse_cnt <= '0;
    end else if (state == TSR_READ && sck_rise) begin
      pulse_cnt <= pulse_cnt + 1'b1;
    end
  end

  // Word offered in the read slot
  always_comb begin
    if (shutdown_active) begin
      read_word = {MAKER_CODE, ID_FILL};
    end else begin
      read_word = {reading, first_conv_done, UNDRIVEN_FILL};
    end
  end

  // Output shift register: load at select, shift on falling clock
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      tx_shift <= '0;
      tx_idx <= '0;
    end else if (state == TSR_IDLE && cs_fall) begin
      tx_shift <= read_word;
      tx_idx <= '0;
    end else if (state == TSR_READ && sck_fall && tx_idx < CNT_W'(DRIVE_BITS)) begin
      tx_shift <= {tx_shift[WORD_BITS-2:0], 1'b0};
      tx_idx <= tx_idx + 1'b1;
    end
  end

  // Line driven only for the first fourteen bits of the read half
  assign sio_out = tx_shift[WORD_BITS-1];
  assign sio_oe_n = !(state == TSR_READ && tx_idx < CNT_W'(DRIVE_BITS));

  // Write half capture on rising clock
  assign next_rx = {rx_shift[WORD_BITS-2:0], sio_s};
  assign word_full = state == TSR_WRITE && sck_rise && rx_cnt == CNT_W'(WORD_BITS - 1);
  assign word_partial = state == TSR_WRITE && !cs_act && rx_cnt >= CNT_W'(PARTIAL_BITS);

  always_ff @(posedge clk_sys) begin
    if (srst || state == TSR_IDLE) begin
      rx_shift <= '0;
      rx_cnt <= '0;
    end else if (state == TSR_WRITE && sck_rise) begin
      rx_shift <= next_rx;
      rx_cnt <= rx_cnt + 1'b1;
    end
  end

  // Mode control register, written only at word or frame end
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mode_control_bits <= MODE_RESET;
    end else if (word_full) begin
      mode_control_bits <= next_rx;
    end else if (word_partial) begin
      mode_control_bits <= rx_shift;
    end
  end

  // Decode: low byte all ones shutdown, anything else continuous
  assign shutdown_active = tsr_is_shutdown(mode_control_bits);

  // Conversion timebase, halted in shutdown and by a full buffer
  assign conv_end = conv_cnt == CONV_CNT_W'(CONV_CYCLES_P - 1);
  assign conv_push = conv_end && !shutdown_active;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      conv_cnt <= '0;
    end else if (!shutdown_active) begin
      if (!conv_end) begin
        conv_cnt <= conv_cnt + 1'b1;
      end else if (buf_in_ready) begin
        conv_cnt <= '0;
      end
    end
  end

  // Finished conversions wait here while a frame is in progress
  tsr_buf u_buf (
    .clk_sys(clk_sys),
    .srst(srst),
    .in_valid(conv_push),
    .in_ready(buf_in_ready),
    .in_data(temp_code),
    .out_valid(buf_out_valid),
    .out_ready(state == TSR_IDLE),
    .out_data(buf_out_data)
  );

  // Reading updated only between frames; bus writes never reach it
  assign load_reading = buf_out_valid && state == TSR_IDLE;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      reading <= '0;
    end else if (load_reading) begin
      reading <= buf_out_data;
    end
  end

  // Sticky first conversion flag
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      first_conv_done <= 1'b0;
    end else if (load_reading) begin
      first_conv_done <= 1'b1;
    end
  end

  // Checks
  a_first_bit_now: assert property (@(posedge clk_sys) disable iff (srst)
    (state == TSR_IDLE && cs_fall) |=> (!sio_oe_n && sio_out == $past(read_word[WORD_BITS-1])))
    else $error("first bit not presented at select");

  a_shift_on_fall: assert property (@(posedge clk_sys) disable iff (srst)
    (state == TSR_READ && sck_fall && cs_act && tx_idx < CNT_W'(DRIVE_BITS - 1))
    |=> sio_out == $past(tx_shift[WORD_BITS-2]))
    else $error("bit not shifted on falling clock");

  a_line_release: assert property (@(posedge clk_sys) disable iff (srst)
    (state == TSR_READ && pulse_cnt > CNT_W'(DRIVE_BITS)) |-> sio_oe_n)
    else $error("line driven after fourteen bits");

  a_no_drive_write: assert property (@(posedge clk_sys) disable iff (srst)
    (state == TSR_WRITE || state == TSR_DONE || state == TSR_IDLE) |-> sio_oe_n)
    else $error("line driven outside read half");

  a_id_in_shutdown: assert property (@(posedge clk_sys) disable iff (srst)
    (state == TSR_IDLE && cs_fall && shutdown_active)
    |=> tx_shift[WORD_BITS-1:2] == {MAKER_CODE, ID_FILL[7:2]})
    else $error("id word not loaded in shutdown");

  a_link_in_shutdown: assert property (@(posedge clk_sys) disable iff (srst)
    (state == TSR_IDLE && cs_fall && shutdown_active) |=> state == TSR_READ)
    else $error("frame not started in shutdown");

  a_temp_slot: assert property (@(posedge clk_sys) disable iff (srst)
    (state == TSR_IDLE && cs_fall && !shutdown_active)
    |=> tx_shift[15:2] == {$past(reading), $past(first_conv_done)})
    else $error("reading word wrong in continuous mode");

  a_mode_apply: assert property (@(posedge clk_sys) disable iff (srst)
    word_full |=> (mode_control_bits == $past(next_rx)
    && shutdown_active == ($past(next_rx[MODE_LOW_W-1:0]) == SHUTDOWN_PATTERN)))
    else $error("full mode word not applied");

  a_mode_hold: assert property (@(posedge clk_sys) disable iff (srst)
    (state == TSR_READ || state == TSR_DONE) |=> $stable(mode_control_bits))
    else $error("mode changed outside write capture");

  a_halt_shutdown: assert property (@(posedge clk_sys) disable iff (srst)
    shutdown_active |=> $stable(conv_cnt) || !shutdown_active)
    else $error("conversion ran in shutdown");

  a_flag_sticky: assert property (@(posedge clk_sys) disable iff (srst)
    first_conv_done |=> first_conv_done)
    else $error("first conversion flag dropped");

  a_flag_cause: assert property (@(posedge clk_sys) disable iff (srst)
    $rose(first_conv_done) |-> $past(load_reading))
    else $error("flag set without a conversion");

  a_reading_cause: assert property (@(posedge clk_sys) disable iff (srst)
    !$stable(reading) |-> $past(load_reading))
    else $error("reading changed without conversion");

  c_full_frame: cover property (@(posedge clk_sys) disable iff (srst) word_full);
  c_id_read: cover property (@(posedge clk_sys) disable iff (srst) state == TSR_IDLE && cs_fall && shutdown_active);
  c_partial: cover property (@(posedge clk_sys) disable iff (srst) word_partial);
  c_stall: cover property (@(posedge clk_sys) disable iff (srst) conv_push && !buf_in_ready);
endmodule
`default_nettype wire

// ==== tsr_pkg.sv ====
// Shared constants for the serial thermal sensor register block
package tsr_pkg;
  // Clock and conversion timebase
  localparam int CLK_HZ = 40000000;
  localparam int CONV_TIME_MS = 300;
  localparam int CONV_CYCLES = CONV_TIME_MS * (CLK_HZ / 1000);
  localparam int CONV_CNT_W = 24;
  // Serial frame layout
  localparam int WORD_BITS = 16;
  localparam int DRIVE_BITS = 14;
  localparam int PARTIAL_BITS = 8;
  localparam int CNT_W = 5;
  // Reading layout: value in 15:3, flag in 2, 1:0 never driven
  localparam int TEMP_W = 13;
  localparam int TEMP_LSB = 3;
  localparam int FLAG_POS = 2;
  localparam int LSB_MICRO_C = 62500;
  // Mode control: low byte all ones means shutdown
  localparam logic [15:0] MODE_RESET = 16'h0000;
  localparam logic [7:0] SHUTDOWN_PATTERN = 8'hff;
  localparam int MODE_LOW_W = 8;
  // Identification word; the code value is arbitrary
  localparam logic [7:0] MAKER_CODE = 8'ha5;
  localparam logic [7:0] ID_FILL = 8'h00;
  localparam logic [1:0] UNDRIVEN_FILL = 2'h0;
  // Buffer depth
  localparam int BUF_DEPTH = 2;

  typedef enum logic [1:0] {
    TSR_IDLE = 2'b00,
    TSR_READ = 2'b01,
    TSR_WRITE = 2'b10,
    TSR_DONE = 2'b11
  } tsr_state_t;

  // Shutdown decode of a mode control word
  function automatic logic tsr_is_shutdown(input logic [15:0] bits);
    tsr_is_shutdown = (bits[MODE_LOW_W-1:0] == SHUTDOWN_PATTERN);
  endfunction
endpackage

// ==== tsr_sync.sv ====
// Two-flop synchroniser for the serial pins
`timescale 1ns/1ps
`default_nettype none
module tsr_sync import tsr_pkg::*; (
  input wire logic clk_sys, // System clock
  input wire logic srst, // Synchronous reset
  input wire logic [2:0] pin_in, // Raw pin levels
  output logic [2:0] pin_sync // Synchronised levels
);
  logic [2:0] stage1;

  // First stage read only by second stage; reset to idle pin levels
  // Select high, clock low, line high, so no false edge follows reset
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      stage1 <= 3'h5;
      pin_sync <= 3'h5;
    end else begin
      stage1 <= pin_in;
      pin_sync <= stage1;
    end
  end
endmodule
`default_nettype wire

// ==== tsr_buf.sv ====
// Two-entry valid/ready buffer for conversion results
`timescale 1ns/1ps
`default_nettype none
module tsr_buf import tsr_pkg::*; (
  input wire logic clk_sys, // System clock
  input wire logic srst, // Synchronous reset
  input wire logic in_valid, // Word offered
  output logic in_ready, // Room for a word
  input wire logic [TEMP_W-1:0] in_data, // Word in
  output logic out_valid, // Word held
  input wire logic out_ready, // Drain accepts
  output logic [TEMP_W-1:0] out_data // Oldest word
);
  logic [TEMP_W-1:0] mem [BUF_DEPTH];
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] count;
  logic push;
  logic pop;

  // Honest full and empty
  assign in_ready = (count != 2'(BUF_DEPTH));
  assign out_valid = (count != 2'h0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Storage
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      count <= count + 2'(push) - 2'(pop);
    end
  end
endmodule
`default_nettype wire

// ==== tsr_master.sv ====
// Serial bus master model driving frames into the sensor
`timescale 1ns/1ps
`default_nettype none
module tsr_master (
  input wire logic clk_sys, // System clock
  input wire logic sio_out, // Device drive value
  input wire logic sio_oe_n, // Device drive enable, low
  output var logic cs_n, // Chip select, low active
  output var logic sck, // Serial clock, idle low
  output logic sio_wire // Resolved line level
);
  logic m_oe = 1'b0;
  logic m_dat = 1'b0;
  // Pulled-up line: device first, then master, else high
  assign sio_wire = !sio_oe_n ? sio_out : (m_oe ? m_dat : 1'b1);
  // Idle pins before the first frame
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
  end
  // One frame: sixteen pulses in, then nwr bits out, MSB first
  // Drive seen during write pulses lands in wdrv, MSB first
  task automatic frame(input logic [15:0] wr, input int nwr, output logic [15:0] rd, output logic [15:0] drv,
    output logic [15:0] wdrv);
    int i;
    wdrv = 16'h0000;
    cs_n <= 1'b0;
    repeat (8) @(posedge clk_sys);
    for (i = 0; i < 16 + nwr; i++) begin
      if (i >= 16) begin
        m_oe <= 1'b1;
        m_dat <= wr[31-i];
      end
      repeat (4) @(posedge clk_sys);
      sck <= 1'b1;
      repeat (2) @(posedge clk_sys);
      // Level is steady through the high phase
      if (i < 16) begin
        rd[15-i] = sio_wire;
        drv[15-i] = !sio_oe_n;
      end else begin
        wdrv[31-i] = !sio_oe_n;
      end
      repeat (2) @(posedge clk_sys);
      sck <= 1'b0;
    end
    repeat (4) @(posedge clk_sys);
    cs_n <= 1'b1;
    m_oe <= 1'b0;
    repeat (8) @(posedge clk_sys);
  endtask
endmodule
`default_nettype wire

// ==== tb_thermal_sensor_serial_regs.sv ====
// Self-checking bench for the serial thermal sensor registers
`timescale 1ns/1ps
`default_nettype none
module tb_thermal_sensor_serial_regs import tsr_pkg::*;;
  localparam int CONV = 40;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [TEMP_W-1:0] temp_code = 13'h0000;
  wire logic cs_n, sck, sio_wire, sio_out, sio_oe_n, shutdown_active, first_conv_done;
  int n_mismatch = 0;
  int compares = 0;
  logic [15:0] rd, drv, wdrv;
  logic sd = 1'b0;
  logic [TEMP_W-1:0] cur = 13'h0000;
  logic [TEMP_W-1:0] vals [5] = '{13'h07d0, 13'h0190, 13'h0001, 13'h1fff, 13'h1c90};
  logic [7:0] codes [11] = '{8'h01, 8'h03, 8'h07, 8'h0f, 8'h1f, 8'h3f, 8'h7f, 8'hff, 8'hfe, 8'hff, 8'h00};
  localparam logic [15:0] IDW = {MAKER_CODE, 6'h00, 2'b11};

  // System clock, 40 MHz
  always #12.5 clk_sys = ~clk_sys;

  tsr_core #(.CONV_CYCLES_P(CONV)) u_tsr_core (
    .clk_sys(clk_sys),
    .srst(srst),
    .cs_n(cs_n),
    .sck(sck),
    .sio_in(sio_wire),
    .sio_out(sio_out),
    .sio_oe_n(sio_oe_n),
    .temp_code(temp_code),
    .shutdown_active(shutdown_active),
    .first_conv_done(first_conv_done)
  );

  tsr_master u_tsr_master (
    .clk_sys(clk_sys),
    .sio_out(sio_out),
    .sio_oe_n(sio_oe_n),
    .cs_n(cs_n),
    .sck(sck),
    .sio_wire(sio_wire)
  );

  // Compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic test_done;
    $display("mismatches=%0d compares=%0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Expected reading word, low two bits pulled high
  function automatic logic [15:0] tw(input logic [TEMP_W-1:0] t, input logic f);
    return {t, f, 2'b11};
  endfunction

  // One frame with its read word checked
  task automatic xfer(input logic [15:0] wr, input int nwr, input logic [15:0] exp);
    u_tsr_master.frame(wr, nwr, rd, drv, wdrv);
    chk(rd, exp);
    chk(drv, 16'hfffc);
    chk(wdrv, 16'h0000);
  endtask

  task automatic mode_chk;
    chk({15'h0000, shutdown_active}, {15'h0000, sd});
  endtask

  // Bound on the whole run
  initial begin
    repeat (100000) @(posedge clk_sys);
    n_mismatch++;
    test_done();
  end

  // Main sequence
  initial begin
    int k;
    repeat (10) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    xfer(16'h0000, 16, tw(13'h0000, 1'b0));
    mode_chk();
    // Table values once conversions have run
    for (k = 0; k < 5; k++) begin
      temp_code <= vals[k];
      cur = vals[k];
      repeat (200) @(posedge clk_sys);
      xfer(16'h0000, 16, tw(cur, 1'b1));
    end
    chk({15'h0000, first_conv_done}, 16'h0001);
    // Frozen reading during a frame, stalled buffer refills after
    fork
      xfer(16'h0000, 16, tw(cur, 1'b1));
      begin
        repeat (50) @(posedge clk_sys);
        temp_code <= 13'h0abc;
      end
    join
    xfer(16'h0000, 16, tw(13'h0abc, 1'b1));
    cur = 13'h0abc;
    // Mode codes, upper byte ignored
    for (k = 0; k < 11; k++) begin
      xfer({8'h5a, codes[k]}, 16, sd ? IDW : tw(cur, 1'b1));
      sd = (codes[k] == 8'hff);
      mode_chk();
    end
    // Partial writes
    xfer(16'hffff, 4, tw(cur, 1'b1));
    mode_chk();
    xfer(16'hff00, 8, tw(cur, 1'b1));
    sd = 1'b1;
    mode_chk();
    // Second reset while in shutdown
    srst <= 1'b1;
    repeat (10) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    sd = 1'b0;
    mode_chk();
    chk({15'h0000, first_conv_done}, 16'h0000);
    xfer(16'h0000, 16, tw(13'h0000, 1'b0));
    repeat (200) @(posedge clk_sys);
    xfer(16'h0000, 16, tw(cur, 1'b1));
    test_done();
  end
endmodule
`default_nettype wire
